// ==== src/pccp_cap_mem.v ====
`timescale 1ns/1ns

// ==========================================================
// Four-word capability store, one write and two registered reads
module pccp_cap_mem (
  input wire clock,
  input wire wr_en,
  input wire [1:0] wr_idx,
  input wire [31:0] wr_data,
  input wire [1:0] rd_a_idx,
  output reg [31:0] rd_a_data_ff,
  input wire [1:0] rd_b_idx,
  output reg [31:0] rd_b_data_ff
);

  reg [31:0] mem [0:3];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_a_data_ff <= mem[rd_a_idx];
    rd_b_data_ff <= mem[rd_b_idx];
  end

endmodule // pccp_cap_mem

// ==== src/pccp_consts.vh ====
`ifndef PCCP_CONSTS_VH
`define PCCP_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define PCCP_OFS_CTRL 8'h00
`define PCCP_OFS_STATUS 8'h04
`define PCCP_OFS_REQID 8'h08
`define PCCP_OFS_DSN_LO 8'h0C
`define PCCP_OFS_DSN_HI 8'h10
`define PCCP_OFS_CRS_CNT 8'h14

// ==========================================================
// Control fields and reset value
`define PCCP_CTRL_ROLE_BIT 0
`define PCCP_CTRL_DSPORT_BIT 1
`define PCCP_CTRL_RESET 2'h0

// ==========================================================
// Status fields
`define PCCP_STAT_HOT_BIT 0
`define PCCP_STAT_IND_BIT 1
`define PCCP_STAT_CSE_BIT 2
`define PCCP_STAT_LOADED_BIT 3
`define PCCP_STAT_LT_LSB 4

// ==========================================================
// Serial number capability words
`define PCCP_CAP_IDX_HDR 2'h0
`define PCCP_CAP_IDX_LO 2'h1
`define PCCP_CAP_IDX_HI 2'h2
`define PCCP_CAP_HDR_VAL 32'h00010003

// ==========================================================
// Completion status codes
`define PCCP_CPL_SC 3'h0
`define PCCP_CPL_CRS 3'h2

// ==========================================================
// Requester ID fields
`define PCCP_RID_BUS_LSB 8
`define PCCP_RID_DEV_LSB 3
`define PCCP_RID_UPSTREAM 16'h0000

// ==========================================================
// Timing
`define PCCP_CLK_PERIOD_NS 100
`define PCCP_HOT_RESET_HOLD_NS 1600
`define PCCP_HOT_RESET_HOLD_CYC ((`PCCP_HOT_RESET_HOLD_NS + `PCCP_CLK_PERIOD_NS - 1) / `PCCP_CLK_PERIOD_NS)

`endif

// ==== src/pccp_ctrl_port.v ====
// Notes on behaviour
// (RULE_01) Root port role: hot reset request drives link state machine into hot reset.
// (RULE_02) Endpoint role: hot reset indication goes high once hot reset is entered.
// (RULE_03) Endpoint with config space enable low answers every config request with retry.
// (RULE_04) User keeps config space enable low while reloading registers after attribute change.
// (RULE_05) User may tie config space enable high if defaults need no change.
// (RULE_06) Root port role ignores config space enable entirely.
// (RULE_07) Serial number bits 31:0 go to lower capability dword.
// (RULE_08) Serial number bits 63:32 go to upper dword, right after lower.
// (RULE_09) Downstream port uses 8-bit bus id as requester ID bus field.
// (RULE_10) Requester ID applies only to internally generated packets, user packets pass unchanged.
// (RULE_11) Downstream port uses 5-bit device id as requester ID device field.
// (RULE_12) Downstream port uses 3-bit function id as requester ID function field.
// (RULE_13) Upstream port disregards downstream bus, device and function ids.
// (RULE_14) Requester ID: bus in 15:8, device in 7:3, function in 2:0.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "pccp_consts.vh"

module pccp_ctrl_port (
  input wire clock,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire hot_reset_req,
  output reg hot_reset_ind,
  output reg ltssm_hot_reset,
  input wire link_hot_reset_rx,
  input wire config_space_enable,
  input wire [63:0] serial_number,
  input wire [7:0] downstream_bus_id,
  input wire [4:0] downstream_device_id,
  input wire [2:0] downstream_function_id,
  input wire cfg_req_valid,
  input wire [1:0] cfg_req_dw_index,
  output reg cfg_cpl_valid,
  output reg [2:0] cfg_cpl_status,
  output reg [31:0] cfg_cpl_data,
  input wire ur_gen_req,
  output reg gen_tlp_valid,
  output reg [15:0] gen_tlp_req_id,
  input wire user_tlp_valid,
  input wire [15:0] user_tlp_req_id,
  output reg tx_tlp_valid,
  output reg [15:0] tx_tlp_req_id
);

  // ==========================================================
  // Local constants
  localparam [1:0] LT_DETECT = 2'h0;
  localparam [1:0] LT_L0 = 2'h1;
  localparam [1:0] LT_HOT_RESET = 2'h2;

  localparam [1:0] LD_LO = 2'h0;
  localparam [1:0] LD_HI = 2'h1;
  localparam [1:0] LD_DONE = 2'h2;

  localparam integer HOLD_CYC_INT = `PCCP_HOT_RESET_HOLD_CYC;
  localparam [7:0] HOLD_CYC = HOLD_CYC_INT[7:0];

  // ==========================================================
  // Declarations
  reg [1:0] ctrl_ff;
  reg [1:0] lt_state_ff;
  reg [1:0] nxt_lt_state;
  reg [7:0] hold_cnt_ff;
  reg [1:0] ld_state_ff;
  reg [1:0] nxt_ld_state;
  reg [63:0] loaded_sn_ff;
  reg cpl_pend_ff;
  reg [2:0] cpl_stat_ff;
  reg apb_wait_ff;
  reg [15:0] crs_cnt_ff;
  reg [31:0] rd_mux;
  reg rd_err;
  reg mem_wr_en;
  reg [1:0] mem_wr_idx;
  reg [31:0] mem_wr_data;
  wire [31:0] cap_cfg_data;
  wire [31:0] cap_apb_data;
  wire link_hot_sync;
  wire role_root;
  wire ds_port;
  wire retry_gate;
  wire [15:0] req_id;
  wire apb_setup;
  wire apb_done;
  wire [1:0] apb_cap_idx;

  assign role_root = ctrl_ff[`PCCP_CTRL_ROLE_BIT];
  assign ds_port = ctrl_ff[`PCCP_CTRL_DSPORT_BIT];
  assign apb_setup = psel & ~penable;
  assign apb_done = psel & penable & pready;
  assign apb_cap_idx = (paddr == `PCCP_OFS_DSN_HI) ? `PCCP_CAP_IDX_HI : `PCCP_CAP_IDX_LO;

  // ==========================================================
  // Link-side hot reset pin synchroniser
  pccp_sync2 u_hot_sync (
    .clock(clock),
    .resetn(resetn),
    .din(link_hot_reset_rx),
    .dout_ff(link_hot_sync)
  );

  // ==========================================================
  // Serial number capability store
  pccp_cap_mem u_cap_mem (
    .clock(clock),
    .wr_en(mem_wr_en),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_a_idx(cfg_req_dw_index),
    .rd_a_data_ff(cap_cfg_data),
    .rd_b_idx(apb_cap_idx),
    .rd_b_data_ff(cap_apb_data)
  );

  // ==========================================================
  // Requester ID assembly
  // (RULE_14) Field packing of ID
  // (RULE_09) Bus field from input
  // (RULE_11) Device field from input
  // (RULE_12) Function field from input
  // (RULE_13) Upstream ignores ids
  assign req_id = ds_port ? {downstream_bus_id, downstream_device_id, downstream_function_id} : `PCCP_RID_UPSTREAM;

  // ==========================================================
  // Config request gating
  // (RULE_03) Endpoint retry gate
  // (RULE_06) Root ignores enable
  assign retry_gate = ~role_root & ~config_space_enable;

  // ==========================================================
  // Link state machine
  always @* begin
    nxt_lt_state = lt_state_ff;
    case (lt_state_ff)
      LT_DETECT: begin
        nxt_lt_state = LT_L0;
      end
      LT_L0: begin
        // (RULE_01) Root request enters hot reset
        if (role_root && hot_reset_req) begin
          nxt_lt_state = LT_HOT_RESET;
        end else if (!role_root && link_hot_sync) begin
          nxt_lt_state = LT_HOT_RESET;
        end
      end
      LT_HOT_RESET: begin
        if (hold_cnt_ff >= HOLD_CYC) begin
          if (role_root ? !hot_reset_req : !link_hot_sync) begin
            nxt_lt_state = LT_DETECT;
          end
        end
      end
      default: begin
        nxt_lt_state = LT_DETECT;
      end
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lt_state_ff <= LT_DETECT;
      hold_cnt_ff <= 8'h00;
      hot_reset_ind <= 1'b0;
      ltssm_hot_reset <= 1'b0;
    end else begin
      lt_state_ff <= nxt_lt_state;
      if (nxt_lt_state != LT_HOT_RESET) begin
        hold_cnt_ff <= 8'h00;
      end else if (hold_cnt_ff != 8'hFF) begin
        hold_cnt_ff <= hold_cnt_ff + 8'h01;
      end
      ltssm_hot_reset <= (nxt_lt_state == LT_HOT_RESET);
      // (RULE_02) Endpoint hot reset indication
      hot_reset_ind <= ~role_root & (nxt_lt_state == LT_HOT_RESET);
    end
  end

  // ==========================================================
  // Serial number loader
  always @* begin
    nxt_ld_state = ld_state_ff;
    mem_wr_en = 1'b0;
    mem_wr_idx = `PCCP_CAP_IDX_HDR;
    mem_wr_data = `PCCP_CAP_HDR_VAL;
    case (ld_state_ff)
      LD_LO: begin
        // (RULE_07) Lower dword load
        mem_wr_en = 1'b1;
        mem_wr_idx = `PCCP_CAP_IDX_LO;
        mem_wr_data = serial_number[31:0];
        nxt_ld_state = LD_HI;
      end
      LD_HI: begin
        // (RULE_08) Upper dword load
        mem_wr_en = 1'b1;
        mem_wr_idx = `PCCP_CAP_IDX_HI;
        mem_wr_data = loaded_sn_ff[63:32];
        nxt_ld_state = LD_DONE;
      end
      LD_DONE: begin
        if (serial_number != loaded_sn_ff) begin
          nxt_ld_state = LD_LO;
        end else begin
          mem_wr_en = 1'b1;
        end
      end
      default: begin
        nxt_ld_state = LD_LO;
      end
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ld_state_ff <= LD_LO;
      loaded_sn_ff <= 64'h0000000000000000;
    end else begin
      ld_state_ff <= nxt_ld_state;
      if (ld_state_ff == LD_LO) begin
        loaded_sn_ff <= serial_number;
      end
    end
  end

  // ==========================================================
  // Config request completion path
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cpl_pend_ff <= 1'b0;
      cpl_stat_ff <= `PCCP_CPL_SC;
      cfg_cpl_valid <= 1'b0;
      cfg_cpl_status <= `PCCP_CPL_SC;
      cfg_cpl_data <= 32'h00000000;
      crs_cnt_ff <= 16'h0000;
    end else begin
      cpl_pend_ff <= cfg_req_valid;
      if (cfg_req_valid) begin
        // (RULE_03) Retry status while gated
        cpl_stat_ff <= retry_gate ? `PCCP_CPL_CRS : `PCCP_CPL_SC;
        if (retry_gate && crs_cnt_ff != 16'hFFFF) begin
          crs_cnt_ff <= crs_cnt_ff + 16'h0001;
        end
      end
      cfg_cpl_valid <= cpl_pend_ff;
      if (cpl_pend_ff) begin
        cfg_cpl_status <= cpl_stat_ff;
        cfg_cpl_data <= (cpl_stat_ff == `PCCP_CPL_CRS) ? 32'h00000000 : cap_cfg_data;
      end
    end
  end

  // ==========================================================
  // Internal and user packet requester IDs
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      gen_tlp_valid <= 1'b0;
      gen_tlp_req_id <= 16'h0000;
      tx_tlp_valid <= 1'b0;
      tx_tlp_req_id <= 16'h0000;
    end else begin
      // (RULE_10) ID on internal packets only
      gen_tlp_valid <= ur_gen_req;
      if (ur_gen_req) begin
        gen_tlp_req_id <= req_id;
      end
      // (RULE_10) User packets pass unchanged
      tx_tlp_valid <= user_tlp_valid;
      if (user_tlp_valid) begin
        tx_tlp_req_id <= user_tlp_req_id;
      end
    end
  end

  // ==========================================================
  // APB read mux
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `PCCP_OFS_CTRL: begin
        rd_mux[1:0] = ctrl_ff;
      end
      `PCCP_OFS_STATUS: begin
        rd_mux[`PCCP_STAT_HOT_BIT] = ltssm_hot_reset;
        rd_mux[`PCCP_STAT_IND_BIT] = hot_reset_ind;
        rd_mux[`PCCP_STAT_CSE_BIT] = config_space_enable;
        rd_mux[`PCCP_STAT_LOADED_BIT] = (ld_state_ff == LD_DONE);
        rd_mux[`PCCP_STAT_LT_LSB+1:`PCCP_STAT_LT_LSB] = lt_state_ff;
      end
      `PCCP_OFS_REQID: begin
        rd_mux[15:0] = req_id;
      end
      `PCCP_OFS_DSN_LO: begin
        rd_mux = cap_apb_data;
      end
      `PCCP_OFS_DSN_HI: begin
        rd_mux = cap_apb_data;
      end
      `PCCP_OFS_CRS_CNT: begin
        rd_mux[15:0] = crs_cnt_ff;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // APB slave: one wait cycle, then ready
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      apb_wait_ff <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_ff <= `PCCP_CTRL_RESET;
    end else begin
      if (apb_done) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
        if (pwrite && paddr == `PCCP_OFS_CTRL) begin
          ctrl_ff <= pwdata[1:0];
        end
      end else if (apb_setup) begin
        apb_wait_ff <= 1'b1;
      end else if (psel && penable && apb_wait_ff) begin
        apb_wait_ff <= 1'b0;
        pready <= 1'b1;
        pslverr <= rd_err;
        prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

endmodule // pccp_ctrl_port

// ==== src/pccp_sync2.v ====
`timescale 1ns/1ns

// ==========================================================
// Two-stage level synchroniser
module pccp_sync2 (
  input wire clock,
  input wire resetn,
  input wire din,
  output reg dout_ff
);

  reg meta_ff;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end

endmodule // pccp_sync2

// ==== verification/pccp_ctrl_port_asserts.sv ====
`timescale 1ns/1ns
`include "pccp_consts.vh"
module pccp_ctrl_port_asserts (
  input logic clock,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic hot_reset_req,
  input logic hot_reset_ind,
  input logic ltssm_hot_reset,
  input logic link_hot_reset_rx,
  input logic config_space_enable,
  input logic [7:0] downstream_bus_id,
  input logic [4:0] downstream_device_id,
  input logic [2:0] downstream_function_id,
  input logic cfg_req_valid,
  input logic cfg_cpl_valid,
  input logic [2:0] cfg_cpl_status,
  input logic [31:0] cfg_cpl_data,
  input logic ur_gen_req,
  input logic gen_tlp_valid,
  input logic [15:0] gen_tlp_req_id,
  input logic user_tlp_valid,
  input logic [15:0] user_tlp_req_id,
  input logic tx_tlp_valid,
  input logic [15:0] tx_tlp_req_id
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Sequences
  sequence s_setup_access;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_hot_held;
    ltssm_hot_reset [*8];
  endsequence
  // ==========================================================
  // Bus and completions
  a_apb_wait_state: assert property (s_setup_access |-> !pready ##1 pready) else $error("apb answer timing wrong");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_cpl_two_later: assert property (cfg_req_valid |-> ##2 cfg_cpl_valid) else $error("config request unanswered");
  a_enabled_no_retry: assert property (
    cfg_req_valid && config_space_enable |-> ##2 cfg_cpl_status == `PCCP_CPL_SC) else $error("retry while enabled");
  a_retry_no_data: assert property (
    cfg_cpl_valid && cfg_cpl_status == `PCCP_CPL_CRS |-> cfg_cpl_data == 32'h00000000) else $error("retry data set");
  // ==========================================================
  // Hot reset
  a_hot_entry_cause: assert property (
    $rose(ltssm_hot_reset) |-> $past(hot_reset_req) || $past(link_hot_reset_rx, 3)) else $error("hot reset uncaused");
  a_hot_min_hold: assert property ($rose(ltssm_hot_reset) |-> s_hot_held) else $error("hot reset too short");
  a_ind_in_hot: assert property (hot_reset_ind |-> ltssm_hot_reset) else $error("indication outside hot reset");
  // ==========================================================
  // Requester ids
  a_gen_id_fields: assert property (ur_gen_req |=> gen_tlp_valid && (gen_tlp_req_id == 16'h0000 ||
    gen_tlp_req_id == $past({downstream_bus_id, downstream_device_id, downstream_function_id})))
    else $error("generated id wrong");
  a_user_id_kept: assert property (
    user_tlp_valid |=> tx_tlp_valid && tx_tlp_req_id == $past(user_tlp_req_id)) else $error("user id altered");
endmodule // pccp_ctrl_port_asserts
bind pccp_ctrl_port pccp_ctrl_port_asserts u_chk (.clock, .resetn, .psel, .penable, .pready, .pslverr,
  .hot_reset_req, .hot_reset_ind, .ltssm_hot_reset, .link_hot_reset_rx, .config_space_enable, .downstream_bus_id,
  .downstream_device_id, .downstream_function_id, .cfg_req_valid, .cfg_cpl_valid, .cfg_cpl_status, .cfg_cpl_data,
  .ur_gen_req, .gen_tlp_valid, .gen_tlp_req_id, .user_tlp_valid, .user_tlp_req_id, .tx_tlp_valid, .tx_tlp_req_id);

// ==== verification/pccp_ctrl_port_tb_top.sv ====
`timescale 1ns/1ns
`include "pccp_consts.vh"
module pccp_ctrl_port_tb_top;
  localparam logic [63:0] SER = 64'h0123456789ABCDEF;
  localparam logic [7:0] BUS = 8'hA5;
  localparam logic [4:0] DEV = 5'h13;
  localparam logic [2:0] FN = 3'h6;
  logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, hot_reset_req = 0, link_hot_reset_rx = 0;
  logic cfg_req_valid = 0, ur_gen_req = 0, user_tlp_valid = 0, reload = 1, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [1:0] cfg_req_dw_index = 2'h0;
  logic [15:0] user_tlp_req_id = 16'h0000;
  wire [31:0] prdata, cfg_cpl_data;
  wire pready, pslverr, hot_reset_ind, ltssm_hot_reset, cse, cfg_cpl_valid, gen_tlp_valid, tx_tlp_valid;
  wire [2:0] cfg_cpl_status, fn;
  wire [15:0] gen_tlp_req_id, tx_tlp_req_id;
  wire [63:0] ser;
  wire [7:0] bus;
  wire [4:0] dev;
  int err_total = 0, comparisons = 0;
  always #50 clock = ~clock;
  pccp_user_model #(.SER(SER), .BUS(BUS), .DEV(DEV), .FN(FN)) u_user (.clock(clock), .resetn(resetn),
    .reload(reload), .config_space_enable(cse), .serial_number(ser), .downstream_bus_id(bus),
    .downstream_device_id(dev), .downstream_function_id(fn));
  pccp_ctrl_port dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hot_reset_req(hot_reset_req), .hot_reset_ind(hot_reset_ind), .ltssm_hot_reset(ltssm_hot_reset),
    .link_hot_reset_rx(link_hot_reset_rx), .config_space_enable(cse), .serial_number(ser),
    .downstream_bus_id(bus), .downstream_device_id(dev), .downstream_function_id(fn),
    .cfg_req_valid(cfg_req_valid), .cfg_req_dw_index(cfg_req_dw_index), .cfg_cpl_valid(cfg_cpl_valid),
    .cfg_cpl_status(cfg_cpl_status), .cfg_cpl_data(cfg_cpl_data), .ur_gen_req(ur_gen_req),
    .gen_tlp_valid(gen_tlp_valid), .gen_tlp_req_id(gen_tlp_req_id), .user_tlp_valid(user_tlp_valid),
    .user_tlp_req_id(user_tlp_req_id), .tx_tlp_valid(tx_tlp_valid), .tx_tlp_req_id(tx_tlp_req_id));
  // ==========================================================
  // Tasks
  task tally_and_finish;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function logic cur(input int s);
    case (s)
      0: return ltssm_hot_reset;
      1: return hot_reset_ind;
      2: return cfg_cpl_valid;
      3: return gen_tlp_valid;
      default: return tx_tlp_valid;
    endcase
  endfunction
  task poll(input int s, input logic v);
    int n;
    n = 0;
    #1;
    while (cur(s) !== v && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (cur(s) !== v) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task cfg(input logic [1:0] ix, input logic [2:0] st, input logic [31:0] d);
    @(posedge clock);
    cfg_req_valid <= 1;
    cfg_req_dw_index <= ix;
    @(posedge clock);
    cfg_req_valid <= 0;
    poll(2, 1);
    chk(cfg_cpl_status, st);
    chk(cfg_cpl_data, d);
  endtask
  task pkt(input logic gen, input logic [15:0] exp);
    @(posedge clock);
    ur_gen_req <= gen;
    user_tlp_valid <= !gen;
    user_tlp_req_id <= exp;
    @(posedge clock);
    ur_gen_req <= 0;
    user_tlp_valid <= 0;
    poll(gen ? 3 : 4, 1);
    chk(gen ? gen_tlp_req_id : tx_tlp_req_id, exp);
  endtask
  // ==========================================================
  // Sequence of scenarios
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1;
    repeat (4) @(posedge clock);
    apb(0, `PCCP_OFS_CTRL, 0);
    chk(rd, 0);
    apb(1, 8'h18, 32'hFFFFFFFF);
    chk(er, 1);
    cfg(2'h1, `PCCP_CPL_CRS, 0);
    cfg(2'h2, `PCCP_CPL_CRS, 0);
    apb(0, `PCCP_OFS_CRS_CNT, 0);
    chk(rd, 2);
    reload <= 0;
    repeat (3) @(posedge clock);
    cfg(2'h1, `PCCP_CPL_SC, SER[31:0]);
    cfg(2'h2, `PCCP_CPL_SC, SER[63:32]);
    apb(0, `PCCP_OFS_DSN_LO, 0);
    chk(rd, SER[31:0]);
    apb(0, `PCCP_OFS_DSN_HI, 0);
    chk(rd, SER[63:32]);
    apb(1, `PCCP_OFS_CTRL, 1);
    reload <= 1;
    repeat (3) @(posedge clock);
    cfg(2'h1, `PCCP_CPL_SC, SER[31:0]);
    @(posedge clock);
    hot_reset_req <= 1;
    poll(0, 1);
    chk(hot_reset_ind, 0);
    repeat (20) @(posedge clock);
    hot_reset_req <= 0;
    poll(0, 0);
    apb(1, `PCCP_OFS_CTRL, 0);
    link_hot_reset_rx <= 1;
    poll(1, 1);
    chk(ltssm_hot_reset, 1);
    @(posedge clock);
    link_hot_reset_rx <= 0;
    poll(0, 0);
    apb(1, `PCCP_OFS_CTRL, 2);
    pkt(1, {BUS, DEV, FN});
    apb(0, `PCCP_OFS_REQID, 0);
    chk(rd, {16'h0000, BUS, DEV, FN});
    pkt(0, 16'h1234);
    apb(1, `PCCP_OFS_CTRL, 0);
    pkt(1, 16'h0000);
    tally_and_finish();
  end
endmodule // pccp_ctrl_port_tb_top

// ==== verification/pccp_user_model.sv ====
`timescale 1ns/1ns
module pccp_user_model #(
  parameter logic [63:0] SER = 64'h0123456789ABCDEF,
  parameter logic [7:0] BUS = 8'hA5,
  parameter logic [4:0] DEV = 5'h13,
  parameter logic [2:0] FN = 3'h6
) (
  input logic clock,
  input logic resetn,
  input logic reload,
  output logic config_space_enable,
  output logic [63:0] serial_number,
  output logic [7:0] downstream_bus_id,
  output logic [4:0] downstream_device_id,
  output logic [2:0] downstream_function_id
);
  logic cse_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) cse_ff <= 1'b0;
    else cse_ff <= !reload;
  end
  assign config_space_enable = cse_ff;
  assign serial_number = SER;
  assign downstream_bus_id = BUS;
  assign downstream_device_id = DEV;
  assign downstream_function_id = FN;
endmodule // pccp_user_model
